// ==== include/aalcr_pkg.sv ====
package aalcr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] AALCR_OFS_K1_LO = 8'h2d;
    localparam logic [7:0] AALCR_OFS_K1_HI = 8'h2e;
    localparam logic [7:0] AALCR_OFS_K2_LO = 8'h2f;
    localparam logic [7:0] AALCR_OFS_K2_HI = 8'h30;
    localparam logic [7:0] AALCR_OFS_PEAK = 8'h31;
    localparam logic [7:0] AALCR_OFS_SFCFG = 8'h32;
    localparam logic [7:0] AALCR_OFS_CFG0 = 8'h33;
    localparam logic [7:0] AALCR_OFS_STATUS = 8'h3f;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] AALCR_RST_PEAK = 8'h42;
    localparam logic [7:0] AALCR_RST_CFG0 = 8'h2b;

    // ------------------------------------------------------------
    // Field codes and decode offsets
    // ------------------------------------------------------------
    localparam logic [1:0] AALCR_START_OFF = 2'h0;
    localparam logic [1:0] AALCR_START_DIRECT = 2'h1;
    localparam logic [1:0] AALCR_START_RSSI = 2'h2;
    localparam logic [1:0] AALCR_START_RECOG = 2'h3;
    localparam logic [2:0] AALCR_FRZ_NEVER = 3'h0;
    localparam logic [2:0] AALCR_FRZ_RSSI = 3'h1;
    localparam logic [2:0] AALCR_FRZ_RECOG = 3'h2;
    localparam logic [2:0] AALCR_FRZ_SYNC = 3'h3;
    localparam logic [2:0] AALCR_FRZ_MANUAL = 3'h4;
    localparam logic [1:0] AALCR_GAIN_AUTO = 2'h3;
    localparam logic [3:0] AALCR_ATTACK_BIAS = 4'h1;
    localparam logic [3:0] AALCR_DECAY_BIAS = 4'h2;
    // Correction in 0.5 dB units: 14.5 dB is 29 half-steps
    localparam logic [5:0] AALCR_CORR_BASE = 6'h1d;
    // Hysteresis in 0.1 dB units: 12.8, 17.1, 21.3, 25.6 dB
    localparam logic [8:0] AALCR_HYS_0 = 9'h080;
    localparam logic [8:0] AALCR_HYS_1 = 9'h0ab;
    localparam logic [8:0] AALCR_HYS_2 = 9'h0d5;
    localparam logic [8:0] AALCR_HYS_3 = 9'h100;
    // Fixed attenuation in dB
    localparam logic [4:0] AALCR_ATT_0 = 5'h00;
    localparam logic [4:0] AALCR_ATT_1 = 5'h0f;
    localparam logic [4:0] AALCR_ATT_2 = 5'h1e;

    // ------------------------------------------------------------
    // Gain loop states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        AALCR_OFF = 5'h01,
        AALCR_WAIT = 5'h02,
        AALCR_RUN = 5'h04,
        AALCR_DELAY = 5'h08,
        AALCR_FROZEN = 5'h10
    } aalcr_state_t;

    // Receiver events seen by the gain loop
    typedef struct packed {
        logic rssi_event;
        logic recog_event;
        logic symbol_sync;
        logic manual_gain_freeze_bit;
        logic channel_change;
        logic config_start;
        logic hold_exit;
        logic hold_exit_init_bit;
        logic delay_tick;
    } aalcr_events_t;

    // Decoded loop settings
    typedef struct packed {
        logic [11:0] freq_int1_coef;
        logic [11:0] freq_int2_coef;
        logic [3:0] attack_shift;
        logic [3:0] decay_shift;
        logic [5:0] corr_half_db;
        logic [8:0] hys_tenth_db;
        logic [4:0] fixed_atten_db;
        logic gain_auto;
    } aalcr_settings_t;

endpackage

// ==== logic/aalcr_config_regs.sv ====
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps

// Function
// (RULE_01) Second coefficient is upper nibble over lower byte
// (RULE_02) Attack gain is two to minus code+1
// (RULE_03) Decay factor is two to minus code+2
// (RULE_04) Restart enabled: channel change, polling, hold exit
// (RULE_05) Freeze select: never, or event plus delay
// (RULE_06) Code 100 freezes on manual host command
// (RULE_07) Host uses wake-up level criterion here too
// (RULE_08) Start select: off, direct, strength, recognition
// (RULE_09) Strength correction 14.5 to 18.0 dB
// (RULE_10) Hysteresis 12.8, 17.1, 21.3, 25.6 dB
// (RULE_11) Gain select fixed 0/-15/-30 or automatic
// (RULE_12) First coefficient is upper nibble over lower byte
// (RULE_13) Unused bits reset to zero, writes ignored
module aalcr_config_regs #(
    parameter int DELAY_W = 8
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Receiver events and shared freeze delay
    input wire aalcr_pkg::aalcr_events_t events_i,
    input wire logic [DELAY_W-1:0] loop_freeze_delay_i,
    // Loop settings and gain loop control
    output aalcr_pkg::aalcr_settings_t settings_o,
    output logic gain_run_o,
    output logic gain_frozen_o,
    output logic gain_restart_o
);
    import aalcr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] k1_hi;
        logic [7:0] k1_lo;
        logic [3:0] k2_hi;
        logic [7:0] k2_lo;
        logic [2:0] attack;
        logic [2:0] decay;
        logic restart_en;
        logic [2:0] freeze_sel;
        logic [1:0] start_sel;
        logic [2:0] dgc;
        logic [1:0] hys;
        logic [1:0] gain;
        aalcr_settings_t set;
        aalcr_state_t fsm;
        logic [DELAY_W-1:0] delay_cnt;
        logic restart;
        logic run;
        logic frozen;
        logic [7:0] rdata;
    } aalcr_regs_t;

    aalcr_regs_t s;
    aalcr_regs_t next_s;
    logic restart_req;
    logic start_hit;
    logic freeze_hit;

    // Restart sources, only honoured when enabled
    always_comb begin
        restart_req = s.restart_en & (events_i.channel_change | events_i.config_start
            | (events_i.hold_exit & events_i.hold_exit_init_bit)); // RULE_04
        case (s.start_sel) // RULE_08
            AALCR_START_DIRECT: start_hit = 1'b1;
            AALCR_START_RSSI: start_hit = events_i.rssi_event;
            AALCR_START_RECOG: start_hit = events_i.recog_event;
            default: start_hit = 1'b0;
        endcase
        case (s.freeze_sel) // RULE_05
            AALCR_FRZ_RSSI: freeze_hit = events_i.rssi_event;
            AALCR_FRZ_RECOG: freeze_hit = events_i.recog_event;
            AALCR_FRZ_SYNC: freeze_hit = events_i.symbol_sync;
            default: freeze_hit = 1'b0; // Unused codes never freeze
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.restart = 1'b0;
        // Register writes keep only defined bits
        if (reg_wr_i) begin
            case (reg_addr_i) // RULE_13
                AALCR_OFS_K1_LO: next_s.k1_lo = reg_wdata_i;
                AALCR_OFS_K1_HI: next_s.k1_hi = reg_wdata_i[3:0];
                AALCR_OFS_K2_LO: next_s.k2_lo = reg_wdata_i;
                AALCR_OFS_K2_HI: next_s.k2_hi = reg_wdata_i[3:0];
                AALCR_OFS_PEAK: begin
                    next_s.attack = reg_wdata_i[6:4];
                    next_s.decay = reg_wdata_i[2:0];
                end
                AALCR_OFS_SFCFG: begin
                    next_s.restart_en = reg_wdata_i[5];
                    next_s.freeze_sel = reg_wdata_i[4:2];
                    next_s.start_sel = reg_wdata_i[1:0];
                end
                AALCR_OFS_CFG0: begin
                    next_s.dgc = reg_wdata_i[6:4];
                    next_s.hys = reg_wdata_i[3:2];
                    next_s.gain = reg_wdata_i[1:0];
                end
                default: ;
            endcase
        end
        // Read data stands only in the cycle after the strobe
        next_s.rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i) // RULE_13
                AALCR_OFS_K1_LO: next_s.rdata = s.k1_lo;
                AALCR_OFS_K1_HI: next_s.rdata = {4'h0, s.k1_hi};
                AALCR_OFS_K2_LO: next_s.rdata = s.k2_lo;
                AALCR_OFS_K2_HI: next_s.rdata = {4'h0, s.k2_hi};
                AALCR_OFS_PEAK: next_s.rdata = {1'b0, s.attack, 1'b0, s.decay};
                AALCR_OFS_SFCFG: next_s.rdata = {2'h0, s.restart_en, s.freeze_sel, s.start_sel};
                AALCR_OFS_CFG0: next_s.rdata = {1'b0, s.dgc, s.hys, s.gain};
                AALCR_OFS_STATUS: next_s.rdata = {3'h0, s.fsm};
                default: next_s.rdata = 8'h00;
            endcase
        end
        // Decoded settings follow the fields one cycle later
        next_s.set.freq_int1_coef = {s.k1_hi, s.k1_lo}; // RULE_12
        next_s.set.freq_int2_coef = {s.k2_hi, s.k2_lo}; // RULE_01
        next_s.set.attack_shift = {1'b0, s.attack} + AALCR_ATTACK_BIAS; // RULE_02
        next_s.set.decay_shift = {1'b0, s.decay} + AALCR_DECAY_BIAS; // RULE_03
        next_s.set.corr_half_db = AALCR_CORR_BASE + {3'h0, s.dgc}; // RULE_09
        case (s.hys) // RULE_10
            2'h0: next_s.set.hys_tenth_db = AALCR_HYS_0;
            2'h1: next_s.set.hys_tenth_db = AALCR_HYS_1;
            2'h2: next_s.set.hys_tenth_db = AALCR_HYS_2;
            default: next_s.set.hys_tenth_db = AALCR_HYS_3;
        endcase
        // Automatic mode leaves the fixed attenuation at zero
        case (s.gain) // RULE_11
            2'h1: next_s.set.fixed_atten_db = AALCR_ATT_1;
            2'h2: next_s.set.fixed_atten_db = AALCR_ATT_2;
            default: next_s.set.fixed_atten_db = AALCR_ATT_0;
        endcase
        next_s.set.gain_auto = (s.gain == AALCR_GAIN_AUTO); // RULE_11
        // Gain loop sequencing
        case (s.fsm)
            AALCR_OFF: begin
                if (s.start_sel != AALCR_START_OFF) begin
                    next_s.fsm = AALCR_WAIT;
                end
            end
            AALCR_WAIT: begin
                if (start_hit) begin
                    next_s.fsm = AALCR_RUN; // RULE_08
                end
            end
            AALCR_RUN: begin
                next_s.delay_cnt = '0;
                if (s.freeze_sel == AALCR_FRZ_MANUAL && events_i.manual_gain_freeze_bit) begin
                    next_s.fsm = AALCR_FROZEN; // RULE_06
                end else if (freeze_hit) begin
                    next_s.fsm = AALCR_DELAY; // RULE_05
                end
            end
            AALCR_DELAY: begin
                // Shared delay counted in ticks of the slow enable
                if (s.delay_cnt >= loop_freeze_delay_i) begin
                    next_s.fsm = AALCR_FROZEN; // RULE_05
                end else if (events_i.delay_tick) begin
                    next_s.delay_cnt = s.delay_cnt + 1'b1;
                end
            end
            AALCR_FROZEN: ;
            default: next_s.fsm = AALCR_OFF;
        endcase
        // Restart beats any other move; start select off beats all
        if (restart_req && s.fsm != AALCR_OFF) begin
            next_s.fsm = AALCR_WAIT; // RULE_04
            next_s.restart = 1'b1;
        end
        if (s.start_sel == AALCR_START_OFF) begin
            next_s.fsm = AALCR_OFF; // RULE_08
        end
        // Status bits come from the next state so each output leaves a flip-flop
        next_s.run = (next_s.fsm == AALCR_RUN) | (next_s.fsm == AALCR_DELAY);
        next_s.frozen = (next_s.fsm == AALCR_FROZEN);
    end

    // Register stage
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.attack <= AALCR_RST_PEAK[6:4];
            s.decay <= AALCR_RST_PEAK[2:0];
            s.dgc <= AALCR_RST_CFG0[6:4];
            s.hys <= AALCR_RST_CFG0[3:2];
            s.gain <= AALCR_RST_CFG0[1:0];
            s.set.attack_shift <= {1'b0, AALCR_RST_PEAK[6:4]} + AALCR_ATTACK_BIAS;
            s.set.decay_shift <= {1'b0, AALCR_RST_PEAK[2:0]} + AALCR_DECAY_BIAS;
            s.set.corr_half_db <= AALCR_CORR_BASE + {3'h0, AALCR_RST_CFG0[6:4]};
            s.set.hys_tenth_db <= AALCR_HYS_2;
            s.set.gain_auto <= 1'b1;
            s.fsm <= AALCR_OFF;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata_o = s.rdata;
    assign settings_o = s.set;
    assign gain_run_o = s.run;
    assign gain_frozen_o = s.frozen;
    assign gain_restart_o = s.restart;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    coef_two_a: assert property (reg_wr_i && reg_addr_i == AALCR_OFS_K2_HI ##2 !$past(reg_wr_i)  // RULE_01
        |-> settings_o.freq_int2_coef[11:8] == $past(reg_wdata_i[3:0], 2))
        else $error("second coefficient upper bits wrong");
    coef_one_a: assert property (reg_wr_i && reg_addr_i == AALCR_OFS_K1_LO ##2 !$past(reg_wr_i)  // RULE_12
        |-> settings_o.freq_int1_coef[7:0] == $past(reg_wdata_i, 2))
        else $error("first coefficient lower bits wrong");
    attack_shift_a: assert property (settings_o.attack_shift == $past(s.attack) + 4'h1) // RULE_02
        else $error("attack shift wrong");
    decay_shift_a: assert property (settings_o.decay_shift == $past(s.decay) + 4'h2) // RULE_03
        else $error("decay shift wrong");
    restart_pulse_a: assert property (s.restart_en && events_i.channel_change && s.fsm != AALCR_OFF // RULE_04
        && s.start_sel != AALCR_START_OFF |=> gain_restart_o && s.fsm == AALCR_WAIT)
        else $error("restart missed");
    never_freeze_a: assert property (s.fsm == AALCR_RUN && s.freeze_sel == AALCR_FRZ_NEVER // RULE_05
        |=> !gain_frozen_o)
        else $error("froze with freeze disabled");
    manual_freeze_a: assert property (s.fsm == AALCR_RUN && s.freeze_sel == AALCR_FRZ_MANUAL // RULE_06
        && events_i.manual_gain_freeze_bit && !restart_req && s.start_sel != 2'h0 |=> gain_frozen_o)
        else $error("manual freeze missed");
    direct_start_a: assert property (s.fsm == AALCR_WAIT && s.start_sel == AALCR_START_DIRECT // RULE_08
        && !restart_req |=> gain_run_o)
        else $error("direct start missed");
    start_off_a: assert property (s.start_sel == AALCR_START_OFF |=> s.fsm == AALCR_OFF) // RULE_08
        else $error("loop not off");
    correction_a: assert property (settings_o.corr_half_db == $past(s.dgc) + 6'h1d) // RULE_09
        else $error("correction wrong");
    hysteresis_a: assert property ($past(s.hys) == 2'h1 |-> settings_o.hys_tenth_db == 9'h0ab) // RULE_10
        else $error("hysteresis wrong");
    gain_auto_a: assert property (settings_o.gain_auto == ($past(s.gain) == 2'h3)) // RULE_11
        else $error("gain mode wrong");
    unused_zero_a: assert property (reg_rd_i && reg_addr_i == AALCR_OFS_PEAK // RULE_13
        |=> reg_rdata_o[7] == 1'b0 && reg_rdata_o[3] == 1'b0)
        else $error("unused bits read nonzero");

    // Field writes land on the next edge
    hi_write_a: assert property (reg_wr_i && reg_addr_i == AALCR_OFS_K2_HI // RULE_01
        |=> s.k2_hi == $past(reg_wdata_i[3:0]))
        else $error("coefficient write lost");
    k1_write_a: assert property (reg_wr_i && reg_addr_i == AALCR_OFS_K1_HI // RULE_12
        |=> s.k1_hi == $past(reg_wdata_i[3:0]))
        else $error("coefficient write lost");
    peak_write_a: assert property (reg_wr_i && reg_addr_i == AALCR_OFS_PEAK // RULE_02
        |=> s.attack == $past(reg_wdata_i[6:4]) && s.decay == $past(reg_wdata_i[2:0]))
        else $error("peak factor write lost");
    start_write_a: assert property (reg_wr_i && reg_addr_i == AALCR_OFS_SFCFG // RULE_05
        |=> s.freeze_sel == $past(reg_wdata_i[4:2]) && s.start_sel == $past(reg_wdata_i[1:0]))
        else $error("start freeze write lost");
    cfg0_write_a: assert property (reg_wr_i && reg_addr_i == AALCR_OFS_CFG0 // RULE_09
        |=> s.dgc == $past(reg_wdata_i[6:4]) && s.hys == $past(reg_wdata_i[3:2]))
        else $error("gain config write lost");

    // Read data falls back to zero with no strobe
    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) // RULE_13
        else $error("read data not cleared");
    sf_unused_a: assert property (reg_rd_i && reg_addr_i == AALCR_OFS_SFCFG // RULE_13
        |=> reg_rdata_o[7:6] == 2'h0)
        else $error("unused start bits nonzero");

    // Remaining decode points of hysteresis and the -15/-30 dB fixed gains
    hys_low_a: assert property ($past(s.hys) == 2'h0 |-> settings_o.hys_tenth_db == 9'h080) // RULE_10
        else $error("low hysteresis wrong");
    hys_mid_a: assert property ($past(s.hys) == 2'h2 |-> settings_o.hys_tenth_db == 9'h0d5) // RULE_10
        else $error("mid hysteresis wrong");
    hys_top_a: assert property ($past(s.hys) == 2'h3 |-> settings_o.hys_tenth_db == 9'h100) // RULE_10
        else $error("top hysteresis wrong");
    atten_mid_a: assert property ($past(s.gain) == 2'h1 |-> settings_o.fixed_atten_db == 5'h0f) // RULE_11
        else $error("mid attenuation wrong");
    atten_max_a: assert property ($past(s.gain) == 2'h2 |-> settings_o.fixed_atten_db == 5'h1e) // RULE_11
        else $error("max attenuation wrong");

    // ------------------------------------------------------------
    // Gain loop assertions
    // ------------------------------------------------------------
    // Hold exit restarts the loop only with its init bit set
    hold_restart_a: assert property (s.restart_en && events_i.hold_exit && events_i.hold_exit_init_bit // RULE_04
        && s.fsm != AALCR_OFF && s.start_sel != AALCR_START_OFF |=> gain_restart_o)
        else $error("hold exit restart missed");
    config_restart_a: assert property (s.restart_en && events_i.config_start && s.fsm != AALCR_OFF // RULE_04
        && s.start_sel != AALCR_START_OFF |=> gain_restart_o)
        else $error("config restart missed");
    restart_off_a: assert property (!s.restart_en |=> !gain_restart_o) // RULE_04
        else $error("restart while disabled");
    // A finished delay freezes, a running one does not
    delay_freeze_a: assert property (s.fsm == AALCR_DELAY && s.delay_cnt >= loop_freeze_delay_i // RULE_05
        && !restart_req && s.start_sel != AALCR_START_OFF |=> gain_frozen_o)
        else $error("delayed freeze missed");
    delay_hold_a: assert property (s.fsm == AALCR_DELAY && s.delay_cnt < loop_freeze_delay_i // RULE_05
        |=> !gain_frozen_o)
        else $error("froze before delay");
    frozen_hold_a: assert property (s.fsm == AALCR_FROZEN && !restart_req // RULE_05
        && s.start_sel != AALCR_START_OFF |=> gain_frozen_o)
        else $error("freeze lost");
    // The manual bit counts only under code 100
    manual_ignore_a: assert property (s.fsm == AALCR_RUN && s.freeze_sel != AALCR_FRZ_MANUAL // RULE_06
        && !freeze_hit |=> !gain_frozen_o)
        else $error("manual bit froze loop");
    // Event starts wait for their own event
    rssi_start_a: assert property (s.fsm == AALCR_WAIT && s.start_sel == AALCR_START_RSSI // RULE_08
        && !events_i.rssi_event |=> !gain_run_o)
        else $error("started without event");
    recog_start_a: assert property (s.fsm == AALCR_WAIT && s.start_sel == AALCR_START_RECOG // RULE_08
        && !events_i.recog_event |=> !gain_run_o)
        else $error("started without event");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    cov_run_c: cover property (s.fsm == AALCR_WAIT ##1 s.fsm == AALCR_RUN);
    cov_delay_c: cover property (s.fsm == AALCR_DELAY ##1 s.fsm == AALCR_FROZEN);
    cov_manual_c: cover property (s.fsm == AALCR_RUN ##1 s.fsm == AALCR_FROZEN);
    cov_restart_c: cover property (gain_restart_o);
    cov_hold_c: cover property (events_i.hold_exit && events_i.hold_exit_init_bit ##1 gain_restart_o);

endmodule

// ==== sim/tb_agc_afc_loop_config_regs.sv ====
`timescale 1ns/1ps

module tb_agc_afc_loop_config_regs;
    import aalcr_pkg::*;

    // ----------
    // Harness
    // ----------
    localparam int E_RSSI = 8;
    localparam int E_RECOG = 7;
    localparam int E_SYNC = 6;
    localparam int E_MAN = 5;
    localparam int E_CHAN = 4;
    localparam int E_CFG = 3;
    localparam int E_HOLD = 2;
    localparam int E_TICK = 0;
    // Expected hysteresis in 0.1 dB and attenuation in dB
    localparam logic [11:0] HYS [4] = '{12'h080, 12'h0ab, 12'h0d5, 12'h100};
    localparam logic [11:0] ATT [4] = '{12'h000, 12'h00f, 12'h01e, 12'h000};
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    aalcr_events_t ev = '0;
    logic [7:0] dly = 8'h00;
    aalcr_settings_t st;
    logic run;
    logic frz;
    logic rs;
    int err_total = 0;
    int tests_run = 0;

    // 250 MHz system clock
    always #2 clk_sys_i = ~clk_sys_i;

    aalcr_config_regs #(.DELAY_W(8)) aalcr_config_regs_inst (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .events_i(ev),
        .loop_freeze_delay_i(dly), .settings_o(st), .gain_run_o(run),
        .gain_frozen_o(frz), .gain_restart_o(rs)
    );

    // Verdict, reached from the main sequence or a spent wait
    task automatic complete_run();
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    // Strobes last one cycle and drop at the edge that takes them
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1;
        chk("reg_rdata_o", {4'h0, exp}, {4'h0, rdata});
        @(posedge clk_sys_i);
        #1;
        chk("reg_rdata_o idle", 12'h000, {4'h0, rdata});
    endtask

    // Settings lag the field registers by one cycle
    task automatic settle();
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask

    // Leaves the sampler 1 ns after the edge that took the event
    task automatic pulse(input int b);
        @(posedge clk_sys_i);
        ev[b] <= 1'b1;
        @(posedge clk_sys_i);
        ev[b] <= 1'b0;
        #1;
    endtask

    task automatic wait_lvl(input bit f, input logic want);
        int n;
        n = 0;
        while (((f ? frz : run) !== want) && n < 16) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        chk(f ? "gain_frozen_o" : "gain_run_o", {11'h0, want}, {11'h0, f ? frz : run});
        // Only a spent bound can leave the level wrong here
        if ((f ? frz : run) !== want) begin
            complete_run();
        end
    endtask

    // Pass through OFF so each start begins clean
    task automatic to_run(input logic [7:0] cfg);
        wr_reg(8'h32, 8'h00);
        wait_lvl(0, 1'b0);
        wr_reg(8'h32, cfg);
        wait_lvl(0, 1'b1);
    endtask

    // ----------
    // Scenarios
    // ----------
    task automatic t_reset();
        rd_reg(8'h30, 8'h00);
        rd_reg(8'h31, 8'h42);
        rd_reg(8'h32, 8'h00);
        rd_reg(8'h33, 8'h2b);
        rd_reg(8'h50, 8'h00);
        chk("attack_shift", 12'h005, st.attack_shift);
        chk("decay_shift", 12'h004, st.decay_shift);
        chk("corr_half_db", 12'h01f, st.corr_half_db);
        chk("hys_tenth_db", 12'h0d5, st.hys_tenth_db);
        chk("gain_auto", 12'h001, st.gain_auto);
        chk("gain_run_o", 12'h000, run);
    endtask

    task automatic t_coef();
        wr_reg(8'h30, 8'hf5);
        wr_reg(8'h2f, 8'ha3);
        wr_reg(8'h2e, 8'h9c);
        wr_reg(8'h2d, 8'h17);
        wr_reg(8'h50, 8'hff);
        settle();
        chk("freq_int2_coef", 12'h5a3, st.freq_int2_coef);
        chk("freq_int1_coef", 12'hc17, st.freq_int1_coef);
        rd_reg(8'h30, 8'h05);
        rd_reg(8'h2e, 8'h0c);
    endtask

    // Unused bits are set on purpose and must not stick
    task automatic t_fields();
        for (int i = 0; i < 8; i++) begin
            wr_reg(8'h31, {1'b1, i[2:0], 1'b1, i[2:0]});
            wr_reg(8'h33, {1'b1, i[2:0], i[1:0], i[1:0]});
            settle();
            chk("attack_shift", 12'(i + 1), st.attack_shift);
            chk("decay_shift", 12'(i + 2), st.decay_shift);
            chk("corr_half_db", 12'(29 + i), st.corr_half_db);
            chk("hys_tenth_db", HYS[i % 4], st.hys_tenth_db);
            chk("fixed_atten_db", ATT[i % 4], st.fixed_atten_db);
            chk("gain_auto", 12'(i % 4 == 3), st.gain_auto);
        end
        rd_reg(8'h31, 8'h77);
        rd_reg(8'h33, 8'h7f);
    endtask

    task automatic t_freeze();
        @(posedge clk_sys_i);
        dly <= 8'h02;
        to_run(8'h05);
        pulse(E_RSSI);
        pulse(E_TICK);
        chk("gain_frozen_o", 12'h000, frz);
        pulse(E_TICK);
        wait_lvl(1, 1'b1);
        @(posedge clk_sys_i);
        dly <= 8'h00;
        for (int i = 2; i < 4; i++) begin
            to_run({3'h0, i[2:0], 2'h1});
            pulse(i == 2 ? E_RECOG : E_SYNC);
            wait_lvl(1, 1'b1);
        end
        // Never-freeze and unused codes ignore every freeze source
        for (int i = 4; i < 8; i++) begin
            to_run({3'h0, i == 4 ? 3'h0 : i[2:0], 2'h1});
            pulse(E_MAN);
            pulse(E_RSSI);
            pulse(E_RECOG);
            pulse(E_SYNC);
            chk("gain_frozen_o", 12'h000, frz);
        end
        to_run(8'h11);
        pulse(E_MAN);
        chk("gain_frozen_o", 12'h001, frz);
        rd_reg(8'h3f, 8'h10);
    endtask

    task automatic t_restart();
        pulse(E_CHAN);
        chk("gain_restart_o", 12'h000, rs);
        wr_reg(8'h32, 8'h31);
        pulse(E_HOLD);
        chk("gain_restart_o", 12'h000, rs);
        pulse(E_CHAN);
        chk("gain_restart_o", 12'h001, rs);
        chk("gain_frozen_o", 12'h000, frz);
        pulse(E_CFG);
        chk("gain_restart_o", 12'h001, rs);
        @(posedge clk_sys_i);
        ev[1] <= 1'b1;
        pulse(E_HOLD);
        chk("gain_restart_o", 12'h001, rs);
        @(posedge clk_sys_i);
        ev[1] <= 1'b0;
    endtask

    // Wrong event must not start the loop, the right one must
    task automatic t_start();
        for (int i = 2; i < 4; i++) begin
            wr_reg(8'h32, 8'h00);
            wait_lvl(0, 1'b0);
            wr_reg(8'h32, 8'(i));
            pulse(i == 2 ? E_RECOG : E_RSSI);
            chk("gain_run_o", 12'h000, run);
            pulse(i == 2 ? E_RSSI : E_RECOG);
            chk("gain_run_o", 12'h001, run);
        end
    endtask

    // Main sequence after a 12-cycle reset
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset();
        t_coef();
        t_fields();
        t_freeze();
        t_restart();
        t_start();
        complete_run();
    end
endmodule
